// ===== logic/lars_pkg.sv
// package for the linear array readout sequencer: sizes and carrier types
package lars_pkg;
	localparam int unsigned SECTION_STAGES = 448;
	localparam int unsigned IDX_W          = 9;
	localparam int unsigned NUM_SECTIONS   = 2;
	localparam logic [IDX_W-1:0] LAST_STAGE = 9'h1BF;
	localparam logic [IDX_W-1:0] FIRST_STAGE = 9'h000;

	// per-section view of the analog path controls
	typedef struct packed {
		logic             readActive;
		logic [IDX_W-1:0] pixelSelect;
		logic             resetPulse;
		logic [IDX_W-1:0] resetIndex;
		logic             endOut;
	} lars_section_s;

	typedef logic [SECTION_STAGES-1:0] lars_chain_t;
endpackage

// ===== logic/lars_sequencer.sv
// readout sequencer for a two-section linear photodiode array
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - a start sampled high on one rising edge loads a token into 448 stages
// - both sections share one clock and may run independently
// - in serial mode section 1 last stage starts section 2, forming 896 stages
// - section 2 end output marks completion and can start a cascaded device
// - token advances one stage per edge selecting one pixel per clock period
// - when the token leaves a stage, that pixel integrator is reset
// - the 897th edge in chained use clears the token, the 898th tristates output
// - a section analog output is high impedance outside its readout phase
// - integration time equals spacing between readouts, set by start spacing
// - sequencing is driven by clock and start inputs, with serialMode choosing what starts section 2
// - each section drives its own output, and only while that section reads
module lars_sequencer (
	input  wire logic                               clock,
	input  wire logic                               rst_b,
	input  wire logic                               startInSec1,
	input  wire logic                               startInSec2,
	input  wire logic                               serialMode,
	output logic                                    endOutSec1,
	output logic                                    endOutSec2,
	output lars_pkg::lars_section_s [lars_pkg::NUM_SECTIONS-1:0] secState,
	output logic                                    pixelOutSec1OeB,
	output logic                                    pixelOutSec2OeB,
	output logic                                    pixelAnalogOutOeB
);
	import lars_pkg::*;

	// token chains, one per section
	lars_chain_t chain_r [NUM_SECTIONS];
	logic [NUM_SECTIONS-1:0] endOut_r;
	logic [NUM_SECTIONS-1:0] startSel;
	lars_section_s [NUM_SECTIONS-1:0] sec_r;
	lars_section_s [NUM_SECTIONS-1:0] sec_nxt;

	// chained use: section 2 takes the token from section 1's last stage on
	// the very edge that empties it, so the 896 pixels follow with no gap
	wire [NUM_SECTIONS-1:0]  lastBit;
	wire [NUM_SECTIONS-1:0]  active;
	logic                    sec2FromChain;

	// section 1 always listens to its own start pin
	assign startSel[0]   = startInSec1;
	// section 2 start pin is ignored while chained
	assign sec2FromChain = serialMode & lastBit[0];
	assign startSel[1]   = serialMode ? sec2FromChain : startInSec2;

	genvar g;
	generate
		for (g = 0; g < NUM_SECTIONS; g++) begin : gSec
			wire [IDX_W-1:0]  idx;
			lars_chain_t      chainNxt;
			logic             resetPulseNxt;
			logic [IDX_W-1:0] resetIndexNxt;
			logic             endNxt;

			// any set stage means the section is reading out
			assign active[g]  = |chain_r[g];
			// the stage about to shift out marks the end of the section
			assign lastBit[g] = chain_r[g][SECTION_STAGES-1];
			assign endNxt     = lastBit[g];
			// start enters stage 0, every other stage takes its neighbour
			assign chainNxt   = {chain_r[g][SECTION_STAGES-2:0], startSel[g]};

			// encode token position one index bit at a time; a single token
			// is assumed, two tokens would merge their indices
			for (genvar b = 0; b < IDX_W; b++) begin : gIdx
				logic hit;
				always_comb begin
					hit = 1'b0;
					for (int i = 0; i < SECTION_STAGES; i++) begin
						if (((i >> b) & 1) == 1) begin
							hit = hit | chain_r[g][i];
						end
					end
				end
				assign idx[b] = hit;
			end

			// the pixel shown last cycle has just lost its token: reset it now
			assign resetPulseNxt = sec_r[g].readActive;
			assign resetIndexNxt = sec_r[g].pixelSelect;

			always_comb begin
				sec_nxt[g].readActive  = active[g];
				sec_nxt[g].pixelSelect = idx;
				sec_nxt[g].resetPulse  = resetPulseNxt;
				sec_nxt[g].resetIndex  = resetIndexNxt;
				sec_nxt[g].endOut      = endNxt;
			end

			// shift one stage per edge; integration time is the start spacing
			always_ff @(posedge clock or negedge rst_b) begin
				if (!rst_b) begin
					chain_r[g]  <= '0;
					endOut_r[g] <= 1'b0;
				end else begin
					chain_r[g]  <= chainNxt;
					endOut_r[g] <= endNxt;
				end
			end
		end
	endgenerate

	// registered view; reset strobe names the pixel whose stage was just left
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sec_r <= '0;
		end else begin
			sec_r <= sec_nxt;
		end
	end

	// outputs: enables active low, drive only while a section reads
	assign secState          = sec_r;
	assign endOutSec1        = endOut_r[0];
	assign endOutSec2        = endOut_r[1];
	assign pixelOutSec1OeB   = ~sec_r[0].readActive;
	assign pixelOutSec2OeB   = ~sec_r[1].readActive;
	// tied output bus: enabled while either section reads, both at once in parallel mode, sharing one clock
	assign pixelAnalogOutOeB = ~(sec_r[0].readActive | sec_r[1].readActive);

endmodule // lars_sequencer

`default_nettype wire

// ===== tb/lars_chk.sv
// port checker for the readout sequencer
`timescale 1ns/1ns
`default_nettype none
module lars_chk import lars_pkg::*; (
	input wire logic clock, rst_b, startInSec1, serialMode, endOutSec1, pixelOutSec1OeB,
	input wire logic endOutSec2, pixelOutSec2OeB, pixelAnalogOutOeB,
	input wire lars_section_s [1:0] secState
);
	wire lars_section_s a = secState[0];
	wire lars_section_s b = secState[1];
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	a_oe_follows: assert property (pixelOutSec1OeB == !a.readActive) else $error("oe");
	a_start_loads: assert property (startInSec1 |-> ##2 a.readActive && a.pixelSelect == FIRST_STAGE) else $error("ld");
	a_pixel_steps: assert property (a.readActive && a.pixelSelect != LAST_STAGE |=> a.readActive && a.pixelSelect == $past(a.pixelSelect) + 9'h001) else $error("st");
	a_reset_follows: assert property (a.readActive |=> a.resetPulse && a.resetIndex == $past(a.pixelSelect)) else $error("rs");
	a_end_last: assert property (a.readActive && a.pixelSelect == LAST_STAGE |-> endOutSec1 ##1 !a.readActive) else $error("en");
	a_end_pulse: assert property (endOutSec1 |=> !endOutSec1) else $error("pu");
	a_chain_start: assert property (serialMode && endOutSec1 |-> ##1 b.readActive && b.pixelSelect == FIRST_STAGE) else $error("ch");
	a_oe2_follows: assert property (pixelOutSec2OeB == !b.readActive) else $error("oe2");
	a_bus_oe: assert property (pixelAnalogOutOeB == !(a.readActive || b.readActive)) else $error("bus");
	a_serial_exclusive: assert property (serialMode |-> !(a.readActive && b.readActive)) else $error("ex");
	a_chain_end: assert property (serialMode && b.readActive && b.pixelSelect == LAST_STAGE |-> endOutSec2 ##1 !b.readActive) else $error("ce");
	a_reset2_follows: assert property (b.readActive |=> b.resetPulse && b.resetIndex == $past(b.pixelSelect)) else $error("rs2");
	a_idle_stays: assert property (!a.readActive && !startInSec1 && !$past(startInSec1) |=> !a.readActive) else $error("id");
endmodule // lars_chk
bind lars_sequencer lars_chk lars_chk_inst (.*);
`default_nettype wire

// ===== tb/lars_ctrl.sv
// controller model: start pulses one rising edge wide, launched at the falling edge
`timescale 1ns/1ns
`default_nettype none
module lars_ctrl (input wire logic clock, input wire logic [1:0] go, output logic [1:0] start);
	initial start = 2'h0;
	always @(negedge clock) start <= go & ~start;
endmodule // lars_ctrl
`default_nettype wire

// ===== tb/lars_sequencer_bench.sv
// bench: counting model against the sequencer
`timescale 1ns/1ns
`default_nettype none
module lars_sequencer_bench;
	logic clock = 0, rst_b = 0, serialMode = 0, oeB;
	logic [1:0] go = 0, start, e, oe;
	lars_pkg::lars_section_s [1:0] secState;
	int mismatches = 0, tests_run = 0, t[2] = '{-1, -1};
	logic [31:0] s = 28343;
	always #5 clock = ~clock;
	lars_ctrl lars_ctrl_inst (.clock, .go, .start);
	lars_sequencer lars_sequencer_inst (.clock, .rst_b, .startInSec1(start[0]),
		.startInSec2(start[1]), .serialMode, .endOutSec1(e[0]), .endOutSec2(e[1]), .secState,
		.pixelOutSec1OeB(oe[0]), .pixelOutSec2OeB(oe[1]), .pixelAnalogOutOeB(oeB));
	function automatic logic [31:0] xs(logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ x << 5;
	endfunction
	function automatic logic [13:0] gt(int i);
		return {oeB, e[i], secState[i].endOut, oe[i], secState[i].readActive,
			t[i] > 0 ? secState[i].pixelSelect : 9'h000};
	endfunction
	function automatic logic [13:0] ex(int i);
		return {t[0] < 1 && t[1] < 1, t[i] == 448, t[i] == 448, t[i] < 1, t[i] > 0,
			9'(t[i] > 0 ? t[i] - 1 : 0)};
	endfunction
	task automatic test_done;
		if (mismatches == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// token age per section; section 2 reads section 1's age before it moves
	always @(posedge clock or negedge rst_b)
		for (int i = 1; i >= 0; i--)
			t[i] = !rst_b ? -1 : ((i && serialMode) ? t[0] == 447 : start[i]) ? 0
				: t[i] inside {[0:447]} ? t[i] + 1 : -1;
	// compare at the falling edge, clear of register updates
	always @(negedge clock) if (rst_b) for (int i = 0; i < 2; i++) begin
		tests_run++;
		if (gt(i) !== ex(i)) begin
			mismatches++;
			$display("CHECK FAILED sec%0d exp %h got %h", i, ex(i), gt(i));
		end
	end
	initial begin #100000; mismatches++; test_done; end // hang guard
	// alternate the mode; random gap before section 2's start pulse, which serial mode ignores
	initial begin
		repeat (8) @(negedge clock);
		rst_b = 1;
		repeat (3) begin
			s = xs(s);
			serialMode = ~serialMode;
			go <= 2'h1;
			repeat (s[4:0] + 1) @(negedge clock) go <= 2'h0;
			go <= 2'h2;
			repeat (999) @(negedge clock) go <= 2'h0;
		end
		test_done;
	end
endmodule // lars_sequencer_bench
`default_nettype wire
